// file: core/cei_edge.sv
/*
  Edge detector on the comparator result bit; pulses hit for one cycle
  on an enabled edge.
  Assumes a synchronous, already released active-low reset.
*/
`timescale 1ns/1ps

module cei_edge
  import cei_pkg::*;
(
  input wire logic clk,
  input wire logic rstSync_n,
  cei_edge_if.det  ei
);

  cei_edge_state_t s_r;
  cei_edge_state_t s_nxt;

  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.prev = ei.result;
    s_nxt.hit  = (ei.riseEn & ei.result & ~s_r.prev)   // [RULE_01]
               | (ei.fallEn & ~ei.result & s_r.prev);  // [RULE_02]
  end

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign ei.hit = s_r.hit;

  edge_cause_a: assert property ( // [RULE_01] [RULE_02]
    @(posedge clk) disable iff (!rstSync_n)
    s_r.hit |-> ($past(ei.riseEn) && $past(ei.result) && !$past(s_r.prev))
             || ($past(ei.fallEn) && !$past(ei.result) && $past(s_r.prev)))
    else $error("edge hit without enabled edge");

endmodule

// file: core/cei_edge_if.sv
/*
  Carrier between the register bank and the edge detector.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps

interface cei_edge_if;
  logic result;
  logic riseEn;
  logic fallEn;
  logic hit;

  modport src (output result, output riseEn, output fallEn, input hit);
  modport det (input result, input riseEn, input fallEn, output hit);
endinterface

// file: core/cei_map.svh
/*
  Offsets, field positions, reset values and route bit positions of the
  comparator edge interrupt and input select block.
  Assumes inclusion by the design and bench files by bare name.
*/
`ifndef CEI_MAP_SVH
`define CEI_MAP_SVH

`define CEI_ADDR_CTRL1     4'h0
`define CEI_ADDR_CFG       4'h1
`define CEI_ADDR_STATUS    4'h2
`define CEI_ADDR_MASK      4'h3

`define CEI_CTRL1_RISE     7
`define CEI_CTRL1_FALL     6
`define CEI_CTRL1_PSEL_HI  5
`define CEI_CTRL1_PSEL_LO  4
`define CEI_CTRL1_UNUSED   3
`define CEI_CTRL1_NSEL_HI  2
`define CEI_CTRL1_NSEL_LO  0
`define CEI_CTRL1_RST      8'h00
`define CEI_CTRL1_WMASK    8'hF7

`define CEI_CFG_POL        0
`define CEI_STAT_FLAG      0
`define CEI_STAT_RESULT    1
`define CEI_MASK_FLAG      0

`define CEI_POS_PIN        0
`define CEI_POS_DAC        1
`define CEI_POS_FREF       2
`define CEI_POS_GND        3

`define CEI_NEG_PIN0       0
`define CEI_NEG_PIN1       1
`define CEI_NEG_FREF       2
`define CEI_NEG_GND        3

`endif

// file: core/cei_pkg.sv
/*
  Types shared by the comparator edge interrupt and input select block.
  Assumes nothing beyond the map header.
*/
package cei_pkg;

  typedef logic [3:0] cei_addr_t;
  typedef logic [7:0] cei_data_t;
  typedef logic [3:0] cei_pos_route_t;
  typedef logic [3:0] cei_neg_route_t;

  typedef enum logic [2:0] {
    CEI_NSEL_PIN0 = 3'h0,
    CEI_NSEL_PIN1 = 3'h1,
    CEI_NSEL_FREF = 3'h6,
    CEI_NSEL_GND  = 3'h7
  } cei_nsel_t;

  typedef struct packed {
    cei_data_t      ctrl1;
    logic           pol;
    logic           flag;
    logic           mask;
    cei_data_t      rdData;
    logic           irq;
    cei_pos_route_t posRoute;
    cei_neg_route_t negRoute;
    logic           result;
  } cei_state_t;

  typedef struct packed {
    logic prev;
    logic hit;
  } cei_edge_state_t;

endpackage

// file: core/cei_top.sv
/*
  Second comparator control register: edge interrupt enables and input
  selects, with the comparator result bit, a sticky interrupt flag and mask.
  Assumes cmpAbove is synchronous to clk and the bus master never
  raises both strobes at once.
*/
// Overview of operation
// RULE_01 - Rising result edge sets flag when enabled
// RULE_02 - Falling result edge sets flag when enabled
// RULE_03 - Bits 5-4 route positive comparator input
// RULE_04 - Bits 2-0 route negative input; some reserved
// RULE_05 - Reset clears all; bit3 zero; code 001 pin1 (route outputs reset to one-hot 4'h1, not zero)
// RULE_06 - Result bit follows compare, optionally inverted
`timescale 1ns/1ps

`include "cei_map.svh"

module cei_top
  import cei_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire cei_pkg::cei_addr_t      addr,
  input  wire cei_pkg::cei_data_t      wdata,
  input  wire logic                    wrStb,
  input  wire logic                    rdStb,
  input  wire logic                    cmpAbove,
  output      cei_pkg::cei_data_t      rdData,
  output      logic                    irq,
  output      cei_pkg::cei_pos_route_t posRoute,
  output      cei_pkg::cei_neg_route_t negRoute,
  output      logic                    resultOut
);

  logic [1:0] rstPipe_r;
  logic       rstSync_n;
  cei_state_t s_r;
  cei_state_t s_nxt;
  logic       wrCtrl1;
  logic       rdStatus;

  cei_edge_if ei ();

  // Reset release synchroniser
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rstPipe_r <= 2'h0;
    else
      rstPipe_r <= {rstPipe_r[0], 1'b1};
  end

  assign rstSync_n = rstPipe_r[1];

  assign wrCtrl1  = wrStb && (addr == `CEI_ADDR_CTRL1);
  assign rdStatus = rdStb && (addr == `CEI_ADDR_STATUS);

  assign ei.result = s_r.result;
  assign ei.riseEn = s_r.ctrl1[`CEI_CTRL1_RISE];
  assign ei.fallEn = s_r.ctrl1[`CEI_CTRL1_FALL];

  cei_edge u_edge (
    .clk       (clk),
    .rstSync_n (rstSync_n),
    .ei        (ei)
  );

  always_comb
  begin
    s_nxt = s_r;

    if (wrStb)
    begin
      unique case (addr)
        `CEI_ADDR_CTRL1: s_nxt.ctrl1 = wdata & `CEI_CTRL1_WMASK;  // [RULE_05]
        `CEI_ADDR_CFG:   s_nxt.pol   = wdata[`CEI_CFG_POL];
        `CEI_ADDR_MASK:  s_nxt.mask  = wdata[`CEI_MASK_FLAG];
        default:         s_nxt.pol   = s_r.pol;
      endcase
    end

    // Result bit, inverted when polarity set
    s_nxt.result = cmpAbove ^ s_r.pol;  // [RULE_06]

    // Read clears the flag; a same-cycle edge wins
    if (rdStatus)
      s_nxt.flag = 1'b0;
    if (ei.hit)
      s_nxt.flag = 1'b1;  // [RULE_01] [RULE_02]

    s_nxt.rdData = 8'h00;
    if (rdStb)
    begin
      unique case (addr)
        `CEI_ADDR_CTRL1:  s_nxt.rdData = s_r.ctrl1;
        `CEI_ADDR_CFG:    s_nxt.rdData[`CEI_CFG_POL] = s_r.pol;
        `CEI_ADDR_STATUS:
        begin
          s_nxt.rdData[`CEI_STAT_FLAG]   = s_r.flag;
          s_nxt.rdData[`CEI_STAT_RESULT] = s_r.result;
        end
        `CEI_ADDR_MASK:   s_nxt.rdData[`CEI_MASK_FLAG] = s_r.mask;
        default:          s_nxt.rdData = 8'h00;
      endcase
    end

    // Positive input route, one-hot
    s_nxt.posRoute = 4'h0;
    unique case (s_nxt.ctrl1[`CEI_CTRL1_PSEL_HI:`CEI_CTRL1_PSEL_LO])  // [RULE_03]
      2'h0: s_nxt.posRoute[`CEI_POS_PIN] = 1'b1;
      2'h1: s_nxt.posRoute[`CEI_POS_DAC] = 1'b1;
      2'h2: s_nxt.posRoute[`CEI_POS_FREF] = 1'b1;
      2'h3: s_nxt.posRoute[`CEI_POS_GND] = 1'b1;
    endcase

    // Negative input route; reserved codes leave it unconnected
    s_nxt.negRoute = 4'h0;
    unique case (s_nxt.ctrl1[`CEI_CTRL1_NSEL_HI:`CEI_CTRL1_NSEL_LO])  // [RULE_04]
      CEI_NSEL_PIN0: s_nxt.negRoute[`CEI_NEG_PIN0] = 1'b1;
      CEI_NSEL_PIN1: s_nxt.negRoute[`CEI_NEG_PIN1] = 1'b1;  // [RULE_05]
      CEI_NSEL_FREF: s_nxt.negRoute[`CEI_NEG_FREF] = 1'b1;
      CEI_NSEL_GND:  s_nxt.negRoute[`CEI_NEG_GND]  = 1'b1;
      default:       s_nxt.negRoute = 4'h0;
    endcase

    s_nxt.irq = s_nxt.flag & s_nxt.mask;
  end

  always_ff @(posedge clk or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      s_r       <= '0;  // [RULE_05]
      s_r.ctrl1 <= `CEI_CTRL1_RST;
      s_r.posRoute <= 4'h1;
      s_r.negRoute <= 4'h1;
    end
    else
      s_r <= s_nxt;
  end

  assign rdData    = s_r.rdData;
  assign irq       = s_r.irq;
  assign posRoute  = s_r.posRoute;
  assign negRoute  = s_r.negRoute;
  assign resultOut = s_r.result;

  rise_sets_flag_a: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rstSync_n)
    $rose(s_r.result) && s_r.ctrl1[`CEI_CTRL1_RISE] && !wrCtrl1 |-> ##2 s_r.flag)
    else $error("rising edge did not set flag");

  fall_sets_flag_a: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rstSync_n)
    $fell(s_r.result) && s_r.ctrl1[`CEI_CTRL1_FALL] && !wrCtrl1 |-> ##2 s_r.flag)
    else $error("falling edge did not set flag");

  rise_blocked_a: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rstSync_n)
    $rose(s_r.result) && !s_r.ctrl1[`CEI_CTRL1_RISE] && !wrCtrl1 |=> !ei.hit)
    else $error("disabled rising edge produced a hit");

  pos_route_a: assert property ( // [RULE_03]
    @(posedge clk) disable iff (!rstSync_n)
    wrCtrl1 |=> s_r.posRoute == (4'h1 << $past(wdata[`CEI_CTRL1_PSEL_HI:`CEI_CTRL1_PSEL_LO])))
    else $error("positive route does not match select");

  neg_route_a: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rstSync_n)
    wrCtrl1 && wdata[`CEI_CTRL1_NSEL_HI:`CEI_CTRL1_NSEL_LO] == 3'h7
      |=> s_r.negRoute == 4'h8)
    else $error("ground select did not route negative input");

  bit3_zero_a: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rstSync_n)
    rdStb && addr == `CEI_ADDR_CTRL1 |=> !rdData[`CEI_CTRL1_UNUSED])
    else $error("unimplemented bit read as one");

  polarity_a: assert property ( // [RULE_06]
    @(posedge clk) disable iff (!rstSync_n)
    !(wrStb && addr == `CEI_ADDR_CFG) |=> resultOut == ($past(cmpAbove) ^ s_r.pol))
    else $error("result bit ignores polarity");

  read_clear_a: assert property ( // [RULE_01]
    @(posedge clk) disable iff (!rstSync_n)
    rdStatus && !ei.hit |=> !s_r.flag && !irq)
    else $error("status read did not clear flag");

  fall_blocked_a: assert property ( // [RULE_02]
    @(posedge clk) disable iff (!rstSync_n)
    $fell(s_r.result) && !s_r.ctrl1[`CEI_CTRL1_FALL] && !wrCtrl1 |=> !ei.hit)
    else $error("disabled falling edge produced a hit");

  set_wins_a: assert property ( // [RULE_01] [RULE_02]
    @(posedge clk) disable iff (!rstSync_n)
    rdStatus && ei.hit |=> s_r.flag && (irq == s_r.mask))
    else $error("edge lost against status read");

  flag_hold_a: assert property ( // [RULE_01] [RULE_02]
    @(posedge clk) disable iff (!rstSync_n)
    s_r.flag && !rdStatus |=> s_r.flag)
    else $error("flag dropped without status read");

  rd_idle_a: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rstSync_n)
    !rdStb |=> rdData == 8'h00)
    else $error("read data outside read cycle");

  ctrl1_store_a: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rstSync_n)
    wrCtrl1 |=> !s_r.ctrl1[`CEI_CTRL1_UNUSED]
      && s_r.ctrl1[`CEI_CTRL1_RISE:`CEI_CTRL1_PSEL_LO]
         == $past(wdata[`CEI_CTRL1_RISE:`CEI_CTRL1_PSEL_LO])
      && s_r.ctrl1[`CEI_CTRL1_NSEL_HI:`CEI_CTRL1_NSEL_LO]
         == $past(wdata[`CEI_CTRL1_NSEL_HI:`CEI_CTRL1_NSEL_LO]))
    else $error("control write stored wrong bits");

  neg_reserved_a: assert property ( // [RULE_04]
    @(posedge clk) disable iff (!rstSync_n)
    wrCtrl1 && wdata[`CEI_CTRL1_NSEL_HI:`CEI_CTRL1_NSEL_LO] inside {[3'h2:3'h5]}
      |=> s_r.negRoute == 4'h0)
    else $error("reserved select routed negative input");

  neg_pin1_a: assert property ( // [RULE_05]
    @(posedge clk) disable iff (!rstSync_n)
    wrCtrl1 && wdata[`CEI_CTRL1_NSEL_HI:`CEI_CTRL1_NSEL_LO] == 3'h1
      |=> s_r.negRoute == 4'h2)
    else $error("second pin select did not route negative input");

endmodule

// file: tb/cei_tb_top.sv
/*
  Self-checking bench for the comparator edge interrupt and input select
  block: register access, input routes, polarity and edge interrupts.
  Assumes the register map header and the one-cycle read data of cei_top.
*/
`timescale 1ns/1ps

`include "cei_map.svh"

module cei_tb_top;
  import cei_pkg::*;

  logic           clk;
  logic           rst_n;
  logic           wrStb;
  logic           rdStb;
  logic           cmpAbove;
  cei_addr_t      addr;
  cei_data_t      wdata;
  cei_data_t      rdData;
  cei_data_t      v;
  logic           irq;
  logic           resultOut;
  cei_pos_route_t posRoute;
  cei_neg_route_t negRoute;
  int             errors;
  int             checkCount;

  cei_top dut (
    .clk       (clk),
    .rst_n     (rst_n),
    .addr      (addr),
    .wdata     (wdata),
    .wrStb     (wrStb),
    .rdStb     (rdStb),
    .cmpAbove  (cmpAbove),
    .rdData    (rdData),
    .irq       (irq),
    .posRoute  (posRoute),
    .negRoute  (negRoute),
    .resultOut (resultOut)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    $display("comparisons %0d mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input cei_data_t seen, input cei_data_t exp);
    checkCount++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input cei_addr_t a, input cei_data_t d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask

  task automatic rd(input cei_addr_t a, output cei_data_t d);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1;
    d = rdData;
  endtask

  // Drive the comparator at an edge, then let the flag path settle
  task automatic drive(input logic c);
    @(posedge clk);
    cmpAbove <= c;
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic edgeRun(input logic [1:0] en, input logic msk);
    wr(`CEI_ADDR_MASK, {7'h00, msk});
    wr(`CEI_ADDR_CTRL1, {en, 6'h00});
    rd(`CEI_ADDR_STATUS, v);
    drive(1'b1);
    chk({7'h00, irq}, {7'h00, en[1] & msk});
    rd(`CEI_ADDR_STATUS, v);
    chk(v, {6'h00, 1'b1, en[1]});
    chk({7'h00, irq}, 8'h00);
    drive(1'b0);
    chk({7'h00, irq}, {7'h00, en[0] & msk});
    rd(`CEI_ADDR_STATUS, v);
    chk(v, {6'h00, 1'b0, en[0]});
  endtask

  initial
  begin
    errors = 0;
    checkCount = 0;
    rst_n = 1'b0;
    wrStb = 1'b0;
    rdStb = 1'b0;
    cmpAbove = 1'b0;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({4'h0, posRoute}, 8'h01);
    chk({4'h0, negRoute}, 8'h01);
    rd(`CEI_ADDR_CTRL1, v);
    chk(v, `CEI_CTRL1_RST);
    wr(`CEI_ADDR_CTRL1, 8'hFF);
    rd(`CEI_ADDR_CTRL1, v);
    chk(v, 8'hF7);
    wr(4'h7, 8'h00);
    wr(`CEI_ADDR_STATUS, 8'hFF);
    rd(`CEI_ADDR_CTRL1, v);
    chk(v, 8'hF7);
    rd(`CEI_ADDR_STATUS, v);
    chk(v, 8'h00);
    wr(`CEI_ADDR_MASK, 8'hFF);
    rd(`CEI_ADDR_MASK, v);
    chk(v, 8'h01);
    wr(`CEI_ADDR_CFG, 8'hFE);
    rd(`CEI_ADDR_CFG, v);
    chk(v, 8'h00);
    rd(4'h7, v);
    chk(v, 8'h00);
    $display("test registers done");
    for (int p = 0; p < 4; p++)
    begin
      wr(`CEI_ADDR_CTRL1, 8'(p << 4));
      chk({4'h0, posRoute}, 8'(1 << p));
    end
    for (int n = 0; n < 8; n++)
    begin
      wr(`CEI_ADDR_CTRL1, 8'(n));
      case (n)
        0: v = 8'h01;
        1: v = 8'h02;
        6: v = 8'h04;
        7: v = 8'h08;
        default: v = 8'h00;
      endcase
      chk({4'h0, negRoute}, v);
      rd(`CEI_ADDR_CTRL1, v);
      chk(v, 8'(n));
    end
    $display("test routes done");
    for (int e = 0; e < 4; e++)
      edgeRun(2'(e), 1'b1);
    edgeRun(2'b11, 1'b0);
    $display("test edges done");
    wr(`CEI_ADDR_MASK, 8'h01);
    rd(`CEI_ADDR_STATUS, v);
    wr(`CEI_ADDR_CFG, 8'h01);
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, resultOut}, 8'h01);
    chk({7'h00, irq}, 8'h01);
    rd(`CEI_ADDR_STATUS, v);
    chk(v, 8'h03);
    drive(1'b1);
    chk({7'h00, resultOut}, 8'h00);
    rd(`CEI_ADDR_CFG, v);
    chk(v, 8'h01);
    rd(`CEI_ADDR_STATUS, v);
    chk(v, 8'h01);
    // Status read lands on the same edge as the hit
    @(posedge clk);
    cmpAbove <= 1'b0;
    @(posedge clk);
    rd(`CEI_ADDR_STATUS, v);
    chk(v, 8'h02);
    rd(`CEI_ADDR_STATUS, v);
    chk(v, 8'h03);
    $display("test polarity done");
    drive(1'b1);
    chk({7'h00, irq}, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({7'h00, irq}, 8'h00);
    chk({4'h0, posRoute}, 8'h01);
    chk({4'h0, negRoute}, 8'h01);
    rd(`CEI_ADDR_CTRL1, v);
    chk(v, 8'h00);
    rd(`CEI_ADDR_CFG, v);
    chk(v, 8'h00);
    rd(`CEI_ADDR_MASK, v);
    chk(v, 8'h00);
    rd(`CEI_ADDR_STATUS, v);
    chk(v, 8'h02);
    $display("test reset done");
    results();
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    errors++;
    results();
  end

endmodule
